// ==== rtl/ufc_regs.vh ====
// register offsets, field positions, reset values and codes of the
// usb function control block; definitions only.
`ifndef UFC_REGS_VH
`define UFC_REGS_VH
// ****************************************************************
// register byte addresses (printed offsets kept as indices)
// ****************************************************************
`define UFC_IDX_CTL 16'hF006
`define UFC_IDX_MSK 16'hF007
`define UFC_IDX_STA 16'hF008
`define UFC_IDX_VEC 16'hF009
`define UFC_ADDR_BITS 18
`define UFC_ADDR_CTL 18'h3C018
`define UFC_ADDR_MSK 18'h3C01C
`define UFC_ADDR_STA 18'h3C020
`define UFC_ADDR_VEC 18'h3C024
// ****************************************************************
// control register fields
// ****************************************************************
`define UFC_CTL_DIR 0
`define UFC_CTL_TSEL_LO 1
`define UFC_CTL_TSEL_HI 3
`define UFC_CTL_ROUTE 4
`define UFC_CTL_RWUP 5
`define UFC_CTL_LPEN 6
`define UFC_CTL_ATTACH 7
`define UFC_CTL_RESET 8'h00
// ****************************************************************
// event bits (status and mask share the layout)
// ****************************************************************
`define UFC_EV_SETUP_OVW 0
`define UFC_EV_SETUP 1
`define UFC_EV_WAKE 2
`define UFC_EV_RESUME 3
`define UFC_EV_SUSPEND 4
`define UFC_EV_FRESET 5
`define UFC_EV_MASK 8'h3F
`define UFC_MSK_RESET 8'h00
`define UFC_STA_RESET 8'h00
// ****************************************************************
// test select codes and vectors
// ****************************************************************
`define UFC_TS_NORMAL 3'h0
`define UFC_TS_SE0_NAK 3'h1
`define UFC_TS_J 3'h2
`define UFC_TS_K 3'h3
`define UFC_TS_PACKET 3'h4
`define UFC_TS_FORCE_FS 3'h5
`define UFC_VEC_NONE 8'h00
`define UFC_VEC_FRESET 8'h38
`define UFC_VEC_SUSPEND 8'h34
`define UFC_VEC_RESUME 8'h30
`define UFC_VEC_WAKE 8'h2C
`define UFC_VEC_SETUP 8'h28
`define UFC_VEC_SETUP_OVW 8'h24
// ****************************************************************
// timing: bus reset pulse held on the core reset output
// ****************************************************************
`define UFC_CORE_RST_NS 100
`define UFC_CLK_NS 10
`define UFC_CORE_RST_CYC (`UFC_CORE_RST_NS / `UFC_CLK_NS)
`endif

// ==== rtl/ufc_event_bit.v ====
// one sticky event flag: hardware sets, software clears by writing 1.
// assumes set and clear pulses are synchronous to clk.
`timescale 1ns/100ps
module ufc_event_bit (
  input wire clk,
  input wire rst,
  input wire softClr,
  input wire hwSet,
  input wire writeOne,
  output reg flag_q
);
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      flag_q <= 1'b0;
    end else if (hwSet) begin
      // set beats a clear arriving in the same cycle
      flag_q <= 1'b1;
    end else if (writeOne || softClr) begin
      flag_q <= 1'b0;
    end
  end
endmodule

// ==== rtl/ufc_test_gen.v ====
// line state generator for the high-speed electrical test modes.
// assumes the packet engine outside replays endpoint zero on request.
`timescale 1ns/100ps
`include "ufc_regs.vh"
module ufc_test_gen (
  input wire clk,
  input wire rst,
  input wire [2:0] testSel,
  input wire packetDone,
  output reg driveJ_q,
  output reg driveK_q,
  output reg packetStart_q,
  output reg forceFs_q
);
  // high while packet mode was already selected last cycle
  reg running_q;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      driveJ_q <= 1'b0;
      driveK_q <= 1'b0;
      packetStart_q <= 1'b0;
      forceFs_q <= 1'b0;
      running_q <= 1'b0;
    end else begin
      // j and k are held by hardware alone while selected
      driveJ_q <= (testSel == `UFC_TS_J);
      driveK_q <= (testSel == `UFC_TS_K);
      // 000 and 001 add nothing special here; 101 only forces full speed
      forceFs_q <= (testSel == `UFC_TS_FORCE_FS);
      // launch on entry, then relaunch each time the last one ends
      running_q <= (testSel == `UFC_TS_PACKET);
      packetStart_q <= (testSel == `UFC_TS_PACKET) &&
                       (packetDone || !running_q);
    end
  end
endmodule

// ==== rtl/ufc_top.v ====
// usb function control: attach, bus reset handling, test modes,
// event flags with mask and vector, registers over ahb-lite.
// assumes one ahb-lite master; sys_rst is the power-up/watchdog reset.
// ****************************************************************
// Summary of operation
// - setting attach bit drives the data-line pullup at once
// - route bit set: bus reset after attach resets the controller
// - control register survives a usb bus reset
// - attach follows only the firmware bit, never automatic
// - detected bus reset sets the function reset flag
// - enabled flag raises interrupt with vector 0x38
// - test select 001 behaves as normal operation
// - se0_nak: firmware sets nak bits; device naks good in tokens
// - test select 010 or 011 drives j or k by hardware
// - test packet mode repeats the packet while selected
// - mask bits 5..0 enable the six event sources
// - mask clears on power-up or watchdog reset
// - usb bus reset leaves mask unchanged
// - each event interrupts only while its mask bit is set
// - events set by hardware; all but the reset flag cleared by writing one
// - reset flag cleared only by power-up or watchdog reset
// - 000 normal, 101 normal with forced full speed
// ****************************************************************
`timescale 1ns/100ps
`include "ufc_regs.vh"
module ufc_top #(
  parameter CORE_RST_CYC = `UFC_CORE_RST_CYC
) (
  input wire ref_clk,
  input wire sys_rst,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  input wire busResetDet,
  input wire setupOvwEvt,
  input wire setupEvt,
  input wire wakeEvt,
  input wire resumeEvt,
  input wire suspendEvt,
  input wire nakAll,
  input wire inTokenCrcOk,
  input wire packetDone,
  output reg pullupEn_q,
  output reg coreReset_q,
  output reg irq_q,
  output reg nakHandshake_q,
  output reg driveJ_q,
  output reg driveK_q,
  output reg packetStart_q,
  output reg forceFs_q,
  output reg [2:0] hsTestSel_q,
  output reg xferDirIn_q,
  output reg remoteWakeEn_q,
  output reg lowPowerEn_q
);
  // ****************************************************************
  // bus reset gate
  // ****************************************************************
  localparam ST_IDLE = 3'b001;
  localparam ST_HOLD = 3'b010;
  localparam ST_WAIT = 3'b100;

  reg [7:0] ctl_q;
  reg [7:0] msk_q;
  reg [7:0] vec_q;
  reg [2:0] rstState_q;
  reg [2:0] rstState_d;
  reg [15:0] rstCnt_q;
  reg busResetSeen_q;
  wire busResetRise;
  wire routedReset;
  wire [5:0] evFlag;
  wire [5:0] evSet;
  wire [5:0] evClr;
  wire genJ;
  wire genK;
  wire genPkt;
  wire genFs;

  assign busResetRise = busResetDet && !busResetSeen_q;
  // a bus reset only counts once the pullup is presented
  assign routedReset = busResetRise && ctl_q[`UFC_CTL_ROUTE] &&
                       ctl_q[`UFC_CTL_ATTACH];

  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      busResetSeen_q <= 1'b0;
    end else begin
      busResetSeen_q <= busResetDet;
    end
  end

  always @* begin
    rstState_d = rstState_q;
    case (rstState_q)
      ST_IDLE: begin
        if (routedReset) begin
          rstState_d = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (rstCnt_q == 16'h0001) begin
          rstState_d = ST_WAIT;
        end
      end
      ST_WAIT: begin
        // wait for the bus reset to end so one reset gives one pulse
        if (!busResetDet) begin
          rstState_d = ST_IDLE;
        end
      end
      default: begin
        rstState_d = ST_IDLE;
      end
    endcase
  end

  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rstState_q <= ST_IDLE;
      rstCnt_q <= 16'h0000;
      coreReset_q <= 1'b0;
    end else begin
      rstState_q <= rstState_d;
      if (rstState_q == ST_IDLE && routedReset) begin
        rstCnt_q <= CORE_RST_CYC[15:0];
      end else if (rstCnt_q != 16'h0000) begin
        rstCnt_q <= rstCnt_q - 16'h0001;
      end
      // with the route bit clear nothing reaches the controller
      coreReset_q <= (rstState_d == ST_HOLD);
    end
  end

  // ****************************************************************
  // ahb-lite slave
  // ****************************************************************
  reg wrPend_q;
  reg [31:0] wrAddr_q;
  wire takeXfer;
  wire [31:0] wrData;
  wire wrCtl;
  wire wrMsk;
  wire wrSta;
  wire wrInMap;
  reg [31:0] rdMux;

  assign takeXfer = hsel && htrans[1] && hready;
  assign wrData = hwdata;
  // decode writes over the full address, as reads do, so no alias
  assign wrInMap = wrPend_q &&
                   (wrAddr_q[31:`UFC_ADDR_BITS] == 14'h0000);
  assign wrCtl = wrInMap &&
                 (wrAddr_q[`UFC_ADDR_BITS-1:0] == `UFC_ADDR_CTL);
  assign wrMsk = wrInMap &&
                 (wrAddr_q[`UFC_ADDR_BITS-1:0] == `UFC_ADDR_MSK);
  assign wrSta = wrInMap &&
                 (wrAddr_q[`UFC_ADDR_BITS-1:0] == `UFC_ADDR_STA);

  always @* begin
    rdMux = 32'h00000000;
    if (haddr[31:`UFC_ADDR_BITS] == 14'h0000) begin
      case (haddr[`UFC_ADDR_BITS-1:0])
        `UFC_ADDR_CTL: rdMux = {24'h000000, ctl_q};
        `UFC_ADDR_MSK: rdMux = {24'h000000, msk_q};
        `UFC_ADDR_STA: rdMux = {26'h0, evFlag};
        `UFC_ADDR_VEC: rdMux = {24'h000000, vec_q};
        default: rdMux = 32'h00000000;
      endcase
    end
  end

  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wrPend_q <= 1'b0;
      wrAddr_q <= 32'h00000000;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wrPend_q <= takeXfer && hwrite;
      if (takeXfer) begin
        wrAddr_q <= haddr;
      end
      // read data registered in the address phase, shown in data phase
      if (takeXfer && !hwrite) begin
        hrdata <= rdMux;
      end
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // ****************************************************************
  // control and mask registers
  // ****************************************************************
  // only sys_rst clears them; the bus reset never touches them
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctl_q <= `UFC_CTL_RESET;
      msk_q <= `UFC_MSK_RESET;
    end else begin
      if (wrCtl) begin
        // attach changes only by this write
        ctl_q <= wrData[7:0];
      end
      if (wrMsk) begin
        // reserved high bits kept writable but unused
        msk_q <= wrData[7:0];
      end
    end
  end

  // ****************************************************************
  // event flags
  // ****************************************************************
  assign evSet = {busResetRise, suspendEvt, resumeEvt, wakeEvt,
                  setupEvt, setupOvwEvt};
  // a written one cannot clear the reset flag
  assign evClr = wrSta ? {1'b0, wrData[4:0]} : 6'h00;

  genvar gi;
  generate
    for (gi = 0; gi < 6; gi = gi + 1) begin : gEv
      // bus reset sets its flag and, when routed, clears the others;
      // only sys_rst clears the reset flag itself
      ufc_event_bit uBit (
        .clk(ref_clk),
        .rst(sys_rst),
        .softClr(gi != `UFC_EV_FRESET && routedReset),
        .hwSet(evSet[gi]),
        .writeOne(evClr[gi]),
        .flag_q(evFlag[gi])
      );
    end
  endgenerate

  // ****************************************************************
  // interrupt and vector
  // ****************************************************************
  wire [5:0] evPend;
  reg [7:0] vecNext;
  assign evPend = evFlag & msk_q[5:0];

  always @* begin
    vecNext = `UFC_VEC_NONE;
    if (evPend[`UFC_EV_FRESET]) begin
      vecNext = `UFC_VEC_FRESET;
    end else if (evPend[`UFC_EV_SUSPEND]) begin
      vecNext = `UFC_VEC_SUSPEND;
    end else if (evPend[`UFC_EV_RESUME]) begin
      vecNext = `UFC_VEC_RESUME;
    end else if (evPend[`UFC_EV_WAKE]) begin
      vecNext = `UFC_VEC_WAKE;
    end else if (evPend[`UFC_EV_SETUP]) begin
      vecNext = `UFC_VEC_SETUP;
    end else if (evPend[`UFC_EV_SETUP_OVW]) begin
      vecNext = `UFC_VEC_SETUP_OVW;
    end
  end

  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      vec_q <= `UFC_VEC_NONE;
      irq_q <= 1'b0;
    end else begin
      vec_q <= vecNext;
      irq_q <= (evPend != 6'h00);
    end
  end

  // ****************************************************************
  // link side outputs
  // ****************************************************************
  ufc_test_gen uTest (
    .clk(ref_clk),
    .rst(sys_rst),
    .testSel(ctl_q[`UFC_CTL_TSEL_HI:`UFC_CTL_TSEL_LO]),
    .packetDone(packetDone),
    .driveJ_q(genJ),
    .driveK_q(genK),
    .packetStart_q(genPkt),
    .forceFs_q(genFs)
  );

  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pullupEn_q <= 1'b0;
      nakHandshake_q <= 1'b0;
      driveJ_q <= 1'b0;
      driveK_q <= 1'b0;
      packetStart_q <= 1'b0;
      forceFs_q <= 1'b0;
      hsTestSel_q <= `UFC_TS_NORMAL;
      xferDirIn_q <= 1'b0;
      remoteWakeEn_q <= 1'b0;
      lowPowerEn_q <= 1'b0;
    end else begin
      // pullup takes the written bit on the same edge as the stored bit
      pullupEn_q <= wrCtl ? wrData[`UFC_CTL_ATTACH] :
                    ctl_q[`UFC_CTL_ATTACH];
      // firmware-set nak bits make every good in token nak
      nakHandshake_q <= nakAll && inTokenCrcOk;
      driveJ_q <= genJ;
      driveK_q <= genK;
      packetStart_q <= genPkt;
      forceFs_q <= genFs;
      hsTestSel_q <= ctl_q[`UFC_CTL_TSEL_HI:`UFC_CTL_TSEL_LO];
      xferDirIn_q <= ctl_q[`UFC_CTL_DIR];
      remoteWakeEn_q <= ctl_q[`UFC_CTL_RWUP];
      lowPowerEn_q <= ctl_q[`UFC_CTL_LPEN];
    end
  end
endmodule

// ==== verification/ufc_top_props.sv ====
// checker of ufc_top: attach, routed bus reset, irq, test modes.
// assumes one ahb-lite master and the bench's CORE_RST_CYC value.
`timescale 1ns/100ps
`include "ufc_regs.vh"
module ufc_top_props #(
  parameter CORE_RST_CYC = 2
) (
  input wire ref_clk,
  input wire sys_rst,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] hwdata,
  input wire hready,
  input wire busResetDet,
  input wire nakAll,
  input wire inTokenCrcOk,
  input wire packetDone,
  input wire pullupEn_q,
  input wire coreReset_q,
  input wire irq_q,
  input wire nakHandshake_q,
  input wire driveJ_q,
  input wire driveK_q,
  input wire packetStart_q,
  input wire [2:0] hsTestSel_q
);
  // ****************************************
  // shadow of firmware writes
  // ****************************************
  reg wrCtl_q;
  reg wrMsk_q;
  reg [7:0] ctl_q;
  reg [7:0] mask_q;
  reg [7:0] hiCnt_q;
  wire wr = hsel & htrans[1] & hready & hwrite;
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wrCtl_q <= 1'b0;
      wrMsk_q <= 1'b0;
      ctl_q <= 8'h00;
      mask_q <= 8'h00;
      hiCnt_q <= 8'h00;
    end else begin
      wrCtl_q <= wr && haddr == {14'h0, `UFC_ADDR_CTL};
      wrMsk_q <= wr && haddr == {14'h0, `UFC_ADDR_MSK};
      if (wrCtl_q) ctl_q <= hwdata[7:0];
      if (wrMsk_q) mask_q <= hwdata[7:0];
      hiCnt_q <= coreReset_q ? hiCnt_q + 8'h01 : 8'h00;
    end
  end
  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  pullup_follow_a: assert property (wrCtl_q |=> ##[0:1]
    pullupEn_q == ctl_q[7]) else $error("pullup misses attach");
  pullup_only_a: assert property (pullupEn_q != $past(pullupEn_q)
    |-> $past(wrCtl_q) || $past(wrCtl_q, 2)) else $error("pullup moved");
  core_routed_a: assert property ($rose(coreReset_q)
    |-> ctl_q[4] && ctl_q[7]) else $error("core reset not routed");
  core_length_a: assert property ($fell(coreReset_q)
    |-> hiCnt_q == CORE_RST_CYC) else $error("core reset length");
  irq_reset_a: assert property ($rose(busResetDet) && mask_q[5]
    |-> ##2 irq_q) else $error("no reset irq");
  irq_mask_a: assert property ($rose(irq_q)
    |-> mask_q[5:0] != 6'h00) else $error("irq while masked");
  test_j_a: assert property ((hsTestSel_q == `UFC_TS_J) [*3]
    |-> driveJ_q && !driveK_q) else $error("j state missing");
  normal_mode_a: assert property ((hsTestSel_q <= 3'h1) [*3]
    |-> !driveJ_q && !driveK_q) else $error("line driven in normal");
  nak_answer_a: assert property (nakAll && inTokenCrcOk
    |-> ##[1:2] nakHandshake_q) else $error("no nak");
  packet_repeat_a: assert property ((hsTestSel_q == 3'h4) [*4]
    ##0 packetDone ##1 (hsTestSel_q == 3'h4) |-> ##1 packetStart_q)
    else $error("no replay");
endmodule
bind ufc_top ufc_top_props #(.CORE_RST_CYC(CORE_RST_CYC)) uProps (
  .ref_clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
  .busResetDet, .nakAll, .inTokenCrcOk, .packetDone, .pullupEn_q,
  .coreReset_q, .irq_q, .nakHandshake_q, .driveJ_q, .driveK_q,
  .packetStart_q, .hsTestSel_q);

// ==== verification/ufc_host_model.sv ====
// upstream host model: bus reset, good in tokens, packet acceptance.
// assumes reset requests from the bench are one-cycle pulses.
`timescale 1ns/100ps
module ufc_host_model (
  input wire ref_clk,
  input wire sys_rst,
  input wire resetReq,
  input wire packetStart,
  output reg busResetDet,
  output reg inTokenCrcOk,
  output reg packetDone
);
  reg [3:0] rstCnt_q;
  reg [3:0] tokCnt_q;
  reg [2:0] pkCnt_q;
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rstCnt_q <= 4'h0;
      tokCnt_q <= 4'h0;
      pkCnt_q <= 3'h0;
      busResetDet <= 1'b0;
      inTokenCrcOk <= 1'b0;
      packetDone <= 1'b0;
    end else begin
      if (resetReq) rstCnt_q <= 4'h6;
      else if (rstCnt_q != 4'h0) rstCnt_q <= rstCnt_q - 4'h1;
      busResetDet <= resetReq || rstCnt_q > 4'h1;
      tokCnt_q <= tokCnt_q + 4'h1;
      inTokenCrcOk <= tokCnt_q == 4'hF;
      // varying packet time gives prompt and slow acceptance
      if (packetStart) pkCnt_q <= {1'b1, tokCnt_q[1:0]};
      else if (pkCnt_q != 3'h0) pkCnt_q <= pkCnt_q - 3'h1;
      packetDone <= pkCnt_q == 3'h1;
    end
  end
endmodule

// ==== verification/usb_function_control_bench.sv ====
// self-checking bench of ufc_top with a host model on the usb side.
// assumes registers are reached only through the ahb-lite task.
`timescale 1ns/100ps
`include "ufc_regs.vh"
`define CHK(nm, e, s) begin check_count = check_count + 1; \
  if ((s) !== (e)) begin num_errors = num_errors + 1; \
  $display("CHECK FAILED %0s exp %0h got %0h", nm, e, s); end end
module usb_function_control_bench;
  localparam RC = 2;
  localparam [31:0] aCtl = {14'h0, `UFC_ADDR_CTL};
  localparam [31:0] aMsk = {14'h0, `UFC_ADDR_MSK};
  localparam [31:0] aSta = {14'h0, `UFC_ADDR_STA};
  localparam [31:0] aVec = {14'h0, `UFC_ADDR_VEC};
  reg ref_clk = 1'b0;
  reg sys_rst = 1'b1;
  reg hsel = 1'b0;
  reg [31:0] haddr = 32'h0;
  reg [1:0] htrans = 2'h0;
  reg hwrite = 1'b0;
  reg [2:0] hsize = 3'h2;
  reg [31:0] hwdata = 32'h0;
  reg nakAll = 1'b0;
  reg resetReq = 1'b0;
  reg [4:0] ev = 5'h00;
  wire hready;
  wire [31:0] hrdata;
  wire hreadyout, hresp, busResetDet, inTokenCrcOk, packetDone;
  wire pullupEn_q, coreReset_q, irq_q, nakHandshake_q, driveJ_q, driveK_q;
  wire packetStart_q, forceFs_q, xferDirIn_q, remoteWakeEn_q, lowPowerEn_q;
  wire [2:0] hsTestSel_q;
  integer num_errors = 0;
  integer check_count = 0;
  integer cyc = 0;
  integer i, n, k;
  reg [31:0] rd;
  reg [7:0] msk, sta, c;
  assign hready = hreadyout;
  always #5 ref_clk = ~ref_clk;
  ufc_top #(.CORE_RST_CYC(RC)) uut (.ref_clk, .sys_rst, .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout,
    .hresp, .busResetDet, .setupOvwEvt(ev[0]), .setupEvt(ev[1]),
    .wakeEvt(ev[2]), .resumeEvt(ev[3]), .suspendEvt(ev[4]), .nakAll,
    .inTokenCrcOk, .packetDone, .pullupEn_q, .coreReset_q, .irq_q,
    .nakHandshake_q, .driveJ_q, .driveK_q, .packetStart_q, .forceFs_q,
    .hsTestSel_q, .xferDirIn_q, .remoteWakeEn_q, .lowPowerEn_q);
  ufc_host_model host (.ref_clk, .sys_rst, .resetReq,
    .packetStart(packetStart_q), .busResetDet, .inTokenCrcOk, .packetDone);
  // ****************************************
  // tasks
  // ****************************************
  task conclude;
    begin
      $display("errors %0d checks %0d", num_errors, check_count);
      if (num_errors == 0 && check_count > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  task xfer(input [31:0] a, input w, input [31:0] d);
    begin
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      @(posedge ref_clk);
      while (hready !== 1'b1) @(posedge ref_clk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge ref_clk);
      while (hready !== 1'b1) @(posedge ref_clk);
      rd = hrdata;
    end
  endtask
  task rdChk(input [31:0] a, input [7:0] e, input [63:0] nm);
    begin
      xfer(a, 1'b0, $urandom);
      `CHK(nm, {24'h0, e}, rd)
    end
  endtask
  task busReset(input integer expCyc);
    begin
      resetReq <= 1'b1;
      @(posedge ref_clk);
      resetReq <= 1'b0;
      n = 0;
      repeat (12) begin
        @(posedge ref_clk);
        n = n + (coreReset_q === 1'b1);
      end
      `CHK("coreRst", expCyc, n)
    end
  endtask
  task tEnd(input [63:0] nm);
    $display("test %0s done", nm);
  endtask
  // cycle budget: the whole run needs well under two thousand cycles
  always @(posedge ref_clk) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      num_errors = num_errors + 1;
      conclude;
    end
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    rd = $urandom(32'hB50A);
    repeat (20) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    rdChk(aCtl, 8'h00, "ctl");
    rdChk(aMsk, 8'h00, "mask");
    rdChk(aSta, 8'h00, "status");
    xfer(32'h100, 1'b1, 32'hFF);
    rdChk(32'h100, 8'h00, "hole");
    for (i = 0; i < 4; i = i + 1) begin
      rd = $urandom;
      msk = rd[7:0] & 8'h3F;
      xfer(aMsk, 1'b1, {rd[31:8], msk});
      rdChk(aMsk, msk, "mask");
    end
    tEnd("regs");
    xfer(aMsk, 1'b1, 32'h20);
    xfer(aCtl, 1'b1, 32'h90);
    repeat (2) @(posedge ref_clk);
    `CHK("pullup", 1'b1, pullupEn_q)
    busReset(RC);
    rdChk(aCtl, 8'h90, "ctl");
    rdChk(aMsk, 8'h20, "mask");
    rdChk(aSta, 8'h20, "status");
    rdChk(aVec, 8'h38, "vector");
    `CHK("irq", 1'b1, irq_q)
    xfer(aSta, 1'b1, 32'h20);
    rdChk(aSta, 8'h20, "status");
    tEnd("busreset");
    for (i = 0; i < 5; i = i + 1) begin
      rd = $urandom;
      msk = rd[7:0] & 8'h1F;
      xfer(aMsk, 1'b1, {24'h0, msk});
      ev <= 5'h01 << i;
      @(posedge ref_clk);
      ev <= 5'h00;
      repeat (3) @(posedge ref_clk);
      `CHK("irq", msk[i], irq_q)
      sta = 8'h20 | (8'h01 << i);
      rdChk(aSta, sta, "status");
      xfer(aSta, 1'b1, 32'h0);
      rdChk(aSta, sta, "status");
      xfer(aSta, 1'b1, 32'h1F);
      rdChk(aSta, 8'h20, "status");
    end
    xfer(aCtl, 1'b1, 32'h80);
    busReset(0);
    tEnd("events");
    nakAll <= 1'b1;
    for (k = 0; k < 6; k = k + 1) begin
      rd = $urandom;
      c = 8'h80 | (k[2:0] << 1) | (rd[7:0] & 8'h61);
      xfer(aCtl, 1'b1, {24'h0, c});
      // let a start launched by the previous mode drain first
      repeat (3) @(posedge ref_clk);
      n = 0;
      i = 0;
      repeat (40) begin
        @(posedge ref_clk);
        n = n + (packetStart_q === 1'b1);
        i = i + (nakHandshake_q === 1'b1);
      end
      `CHK("sel", k[2:0], hsTestSel_q)
      `CHK("j", k == 2, driveJ_q)
      `CHK("k", k == 3, driveK_q)
      `CHK("fs", k == 5, forceFs_q)
      `CHK("dir", c[0], xferDirIn_q)
      `CHK("rwup", c[5], remoteWakeEn_q)
      `CHK("lpen", c[6], lowPowerEn_q)
      `CHK("replay", 1'b1, (k == 4) ? n > 2 : n == 0)
      `CHK("nak", 1'b1, i > 0)
    end
    tEnd("testmode");
    xfer(aMsk, 1'b1, 32'h3F);
    sys_rst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    rdChk(aMsk, 8'h00, "mask");
    `CHK("pullup", 1'b0, pullupEn_q)
    rdChk(aSta, 8'h00, "status");
    tEnd("rerun");
    conclude;
  end
endmodule
